//--- rtl/cdsr_defines.svh
// offsets, field positions and timing counts of the status readout bank
`ifndef CDSR_DEFINES_SVH
`define CDSR_DEFINES_SVH

// read address width, read data width and event flag count
`define CDSR_ADDR_W 7
`define CDSR_DATA_W 12
`define CDSR_EVT_W 12

// read address map
`define CDSR_OFS_PRIMARY_STATUS 7'h00
`define CDSR_OFS_SECONDARY_STATUS 7'h01
`define CDSR_OFS_STICKY_EVENTS 7'h02
`define CDSR_OFS_PORT_ONE 7'h04
`define CDSR_OFS_PORT_TWO 7'h05
`define CDSR_OFS_PORT_THREE 7'h06
`define CDSR_OFS_RX_CORR0 7'h10
`define CDSR_OFS_RX_CORR1 7'h11
`define CDSR_OFS_RX_CORR2 7'h12
`define CDSR_OFS_RX_CORR_TAIL 7'h13
`define CDSR_OFS_RX_RAW0 7'h18
`define CDSR_OFS_RX_RAW1 7'h19
`define CDSR_OFS_RX_RAW2 7'h1a
`define CDSR_OFS_RX_RAW3 7'h1b
`define CDSR_OFS_RX_RAW4 7'h1c
`define CDSR_OFS_VOTE_REPEATS 7'h1d
`define CDSR_OFS_AUDIO_ADC 7'h20
`define CDSR_OFS_TONE_MEASURE 7'h30

// primary status field positions
`define CDSR_P1_RX_AVAIL 0
`define CDSR_P1_TX_AVAIL 1
`define CDSR_P1_TX_ABORT 2
`define CDSR_P1_TX_ACTIVE 3
`define CDSR_P1_RCC_BUSY 4
`define CDSR_P1_TIMER_ZERO 5
`define CDSR_P1_BAND_LO 6
`define CDSR_P1_BAND_HI 7

// secondary status field positions
`define CDSR_P2_AUDIO_ACTIVE 0
`define CDSR_P2_VOICE_MSG 1
`define CDSR_P2_CTRL_SYNC 2

// reset values of the read answer and the sticky events
`define CDSR_DATA_RESET 12'h000
`define CDSR_EVT_RESET 12'h000

// cycles from a taken read to its answer
`define CDSR_READ_LATENCY 1

`endif

//--- rtl/cdsr_pkg.sv
// types shared by the status readout bank
`default_nettype none

package cdsr_pkg;

	// measured tone band as reported in the primary status word
	typedef enum logic [1:0]
	{
		CDSR_BAND_INVALID = 2'b00,
		CDSR_BAND_LOW = 2'b01,
		CDSR_BAND_MID = 2'b10,
		CDSR_BAND_HIGH = 2'b11
	} cdsr_band_e;

	typedef logic [6:0] cdsr_addr_t;
	typedef logic [11:0] cdsr_data_t;

endpackage : cdsr_pkg

`default_nettype wire

//--- rtl/cdsr_sticky_bit.sv
// one sticky event flag: set by a pulse, cleared by the reader, set wins
`timescale 1ns/10ps
`default_nettype none
`include "cdsr_defines.svh"

module cdsr_sticky_bit
(
	input wire logic clk, // device clock
	input wire logic rst, // synchronous reset, active high
	input wire logic set_pulse, // event seen this cycle
	input wire logic clr_pulse, // flag reported to the reader
	output var logic flag // sticky flag
);

	logic flag_ff;
	logic nxt_flag;

	// a set in the clearing cycle survives
	assign nxt_flag = set_pulse | (flag_ff & ~clr_pulse); // R5 R6 R17

	// flag storage
	always_ff @(posedge clk)
	begin
		if (rst)
			flag_ff <= 1'b0;
		else
			flag_ff <= nxt_flag;
	end

	assign flag = flag_ff;

endmodule : cdsr_sticky_bit

`default_nettype wire

//--- rtl/cdsr_status_readout.sv
// read-side register bank: status words, sticky events, port pins, rx words, tone
// Functional notes
// (R1) Address 00 returns receive-ready, transmit-buffer-free, abort/arbitration, encoder-busy, reverse-channel-busy and timer-zero in bits 0 to 5.
// (R2) Bits 7:6 of address 00 carry the tone band: 01 low, 10 middle, 11 high, 00 invalid tone.
// (R3) Address 01 returns audio-interface-active, voice-message-receiving and control-frame-sync in bits 0 to 2.
// (R4) Address 02 returns twelve event flags in the documented order.
// (R5) An event flag is set whenever its event occurs, interrupt enables notwithstanding.
// (R6) The event flags report only what happened since the last read of address 02, so that read clears them.
// (R7) Addresses 04, 05 and 06 return the live states of the three general ports, 8, 8 and 4 bits wide.
// (R8) Addresses 10, 11 and 12 return corrected receive bits 27-20, 19-12 and 11-4.
// (R9) Address 13 returns corrected receive bits 3-0 together with the decode status.
// (R10) Addresses 18 to 1c return the forty uncorrected bits, most significant byte first.
// (R11) Address 1d returns the four-bit count of repeats used by the majority vote.
// (R12) Address 20 returns the last conversion result fetched from the audio processor.
// (R13) Address 30 returns the eight-bit tone frequency measurement.
// (R14) In address 13, bits 7:4 are data bits 3:0 and bits 3:0 are the decode status.
// (R15) The tone measurement is a two's-complement offset from 6 kHz in 1 Hz steps.
// (R16) The host trusts address 20 only after the audio interface has finished its read; the host model stops waiting after 50 cycles and reads anyway.
// (R17) An event arriving in the cycle of an event-register read stays set afterwards.
`timescale 1ns/10ps
`default_nettype none
`include "cdsr_defines.svh"

module cdsr_status_readout
(
	input wire logic CLK, // device clock, 100 MHz
	input wire logic SYS_RST, // synchronous reset, active high
	input wire logic RD_REQ, // one-cycle read request
	input wire logic [6:0] RD_ADDR, // read address
	output var logic [11:0] RD_DATA, // read answer, low bits significant
	output var logic RD_ACK, // answer valid, one-cycle pulse
	input wire logic RX_DATA_AVAIL, // received word waiting
	input wire logic TX_BUF_AVAIL, // transmit buffer free
	input wire logic TX_ABORT_ARB, // last transmit aborted or lost arbitration
	input wire logic TX_ENC_ACTIVE, // transmit encoder running
	input wire logic RCC_BUSY, // reverse control channel busy
	input wire logic TIMER_ZERO, // counter/timer at zero
	input wire logic [1:0] TONE_BAND, // tone band code from the detector
	input wire logic AUDIO_IF_ACTIVE, // audio processor interface busy
	input wire logic VOICE_MSG_RX, // voice channel message arriving
	input wire logic CTRL_FRAME_SYNC, // forward control frame sync held
	input wire logic [11:0] EVENT_PULSE, // one-cycle event strobes, documented order
	input wire logic [7:0] GENERAL_PORT_ONE, // pin levels of port one
	input wire logic [7:0] GENERAL_PORT_TWO, // pin levels of port two
	input wire logic [3:0] GENERAL_PORT_THREE, // pin levels of port three
	input wire logic [27:0] RX_CORRECTED, // corrected received data
	input wire logic [3:0] DECODE_STATUS, // error-correction status code
	input wire logic [39:0] RX_RAW, // uncorrected received bits
	input wire logic [3:0] VOTE_REPEATS, // repeats used by the vote
	input wire logic [7:0] AUDIO_ADC_RESULT, // last audio conversion result
	input wire logic [7:0] TONE_OFFSET // tone offset from 6 kHz, 1 Hz steps
);

	logic [11:0] rd_data_ff;
	logic rd_ack_ff;
	logic [11:0] nxt_rd_data;
	wire logic [11:0] evt_flags;
	logic evt_read;
	cdsr_pkg::cdsr_band_e band;

	// address hits
	wire hit_p1 = RD_ADDR == `CDSR_OFS_PRIMARY_STATUS;
	wire hit_p2 = RD_ADDR == `CDSR_OFS_SECONDARY_STATUS;
	wire hit_evt = RD_ADDR == `CDSR_OFS_STICKY_EVENTS;
	wire hit_g1 = RD_ADDR == `CDSR_OFS_PORT_ONE;
	wire hit_g2 = RD_ADDR == `CDSR_OFS_PORT_TWO;
	wire hit_g3 = RD_ADDR == `CDSR_OFS_PORT_THREE;
	wire hit_c0 = RD_ADDR == `CDSR_OFS_RX_CORR0;
	wire hit_c1 = RD_ADDR == `CDSR_OFS_RX_CORR1;
	wire hit_c2 = RD_ADDR == `CDSR_OFS_RX_CORR2;
	wire hit_c3 = RD_ADDR == `CDSR_OFS_RX_CORR_TAIL;
	wire hit_r0 = RD_ADDR == `CDSR_OFS_RX_RAW0;
	wire hit_r1 = RD_ADDR == `CDSR_OFS_RX_RAW1;
	wire hit_r2 = RD_ADDR == `CDSR_OFS_RX_RAW2;
	wire hit_r3 = RD_ADDR == `CDSR_OFS_RX_RAW3;
	wire hit_r4 = RD_ADDR == `CDSR_OFS_RX_RAW4;
	wire hit_vr = RD_ADDR == `CDSR_OFS_VOTE_REPEATS;
	wire hit_adc = RD_ADDR == `CDSR_OFS_AUDIO_ADC;
	wire hit_tone = RD_ADDR == `CDSR_OFS_TONE_MEASURE;
	wire hit_any = hit_p1 | hit_p2 | hit_evt | hit_g1 | hit_g2 | hit_g3 | hit_c0 | hit_c1
		| hit_c2 | hit_c3 | hit_r0 | hit_r1 | hit_r2 | hit_r3 | hit_r4 | hit_vr | hit_adc
		| hit_tone; // any mapped address

	// status word images
	assign band = cdsr_pkg::cdsr_band_e'(TONE_BAND);
	wire [7:0] primary_status = {band, TIMER_ZERO, RCC_BUSY, TX_ENC_ACTIVE, // R1 R2
		TX_ABORT_ARB, TX_BUF_AVAIL, RX_DATA_AVAIL}; // R1
	wire [2:0] secondary_status = {CTRL_FRAME_SYNC, VOICE_MSG_RX, AUDIO_IF_ACTIVE}; // R3
	wire [7:0] corr_tail = {RX_CORRECTED[3:0], DECODE_STATUS}; // R9 R14

	// read data selection; unmapped addresses answer zero
	wire [11:0] sel_status = ({12{hit_p1}} & {4'h0, primary_status}) // R1 R2
		| ({12{hit_p2}} & {9'h000, secondary_status}) // R3
		| ({12{hit_evt}} & evt_flags); // R4
	wire [11:0] sel_ports = ({12{hit_g1}} & {4'h0, GENERAL_PORT_ONE}) // R7
		| ({12{hit_g2}} & {4'h0, GENERAL_PORT_TWO})
		| ({12{hit_g3}} & {8'h00, GENERAL_PORT_THREE});
	wire [11:0] sel_corr = ({12{hit_c0}} & {4'h0, RX_CORRECTED[27:20]}) // R8
		| ({12{hit_c1}} & {4'h0, RX_CORRECTED[19:12]})
		| ({12{hit_c2}} & {4'h0, RX_CORRECTED[11:4]})
		| ({12{hit_c3}} & {4'h0, corr_tail}); // R9
	wire [11:0] sel_raw = ({12{hit_r0}} & {4'h0, RX_RAW[39:32]}) // R10
		| ({12{hit_r1}} & {4'h0, RX_RAW[31:24]})
		| ({12{hit_r2}} & {4'h0, RX_RAW[23:16]})
		| ({12{hit_r3}} & {4'h0, RX_RAW[15:8]})
		| ({12{hit_r4}} & {4'h0, RX_RAW[7:0]})
		| ({12{hit_vr}} & {8'h00, VOTE_REPEATS}); // R11
	wire [11:0] sel_misc = ({12{hit_adc}} & {4'h0, AUDIO_ADC_RESULT}) // R12
		| ({12{hit_tone}} & {4'h0, TONE_OFFSET}); // R13 R15
	assign nxt_rd_data = sel_status | sel_ports | sel_corr | sel_raw | sel_misc;

	// a read of the event word hands over every flag it reports
	assign evt_read = RD_REQ & hit_evt; // R6

	// twelve sticky event flags, independent of interrupt enables
	genvar gi;
	generate
		for (gi = 0; gi < `CDSR_EVT_W; gi = gi + 1)
		begin : g_evt
			cdsr_sticky_bit u_bit
			(
				.clk(CLK),
				.rst(SYS_RST),
				.set_pulse(EVENT_PULSE[gi]), // R5 R17
				.clr_pulse(evt_read), // R6
				.flag(evt_flags[gi])
			);
		end
	endgenerate

	// registered read answer, held until the next read
	always_ff @(posedge CLK)
	begin
		if (SYS_RST)
			rd_data_ff <= `CDSR_DATA_RESET;
		else if (RD_REQ)
			rd_data_ff <= nxt_rd_data;
	end

	// answer strobe one cycle after the request
	always_ff @(posedge CLK)
	begin
		if (SYS_RST)
			rd_ack_ff <= 1'b0;
		else
			rd_ack_ff <= RD_REQ;
	end

	assign RD_DATA = rd_data_ff;
	assign RD_ACK = rd_ack_ff;

	// checks on the answers and the event flags
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (SYS_RST);

	AST_PRIMARY_FLAGS: assert property (RD_REQ && hit_p1 |=> RD_ACK && // R1
		RD_DATA[5:0] == $past({TIMER_ZERO, RCC_BUSY, TX_ENC_ACTIVE, TX_ABORT_ARB,
		TX_BUF_AVAIL, RX_DATA_AVAIL}))
		else $error("primary status flags wrong");

	AST_PRIMARY_BAND: assert property (RD_REQ && hit_p1 |=> // R2
		RD_DATA[7:6] == $past(TONE_BAND) && RD_DATA[11:8] == 4'h0)
		else $error("tone band field wrong");

	AST_SECONDARY: assert property (RD_REQ && hit_p2 |=> // R3
		RD_DATA == {9'h000, $past(CTRL_FRAME_SYNC), $past(VOICE_MSG_RX),
		$past(AUDIO_IF_ACTIVE)})
		else $error("secondary status wrong");

	AST_EVT_REPORT: assert property (evt_read |=> RD_DATA == $past(evt_flags)) // R4
		else $error("event word not reported");

	AST_EVT_SET: assert property (EVENT_PULSE != 12'h000 |=> // R5
		(evt_flags & $past(EVENT_PULSE)) == $past(EVENT_PULSE))
		else $error("event pulse not latched");

	AST_EVT_CLEAR: assert property (evt_read && EVENT_PULSE == 12'h000 |=> // R6
		evt_flags == 12'h000)
		else $error("event read did not clear");

	AST_EVT_HOLD: assert property (!evt_read |=> // R6
		(evt_flags & $past(evt_flags)) == $past(evt_flags))
		else $error("event flag lost without read");

	AST_SET_WINS: assert property (evt_read && EVENT_PULSE != 12'h000 |=> // R17
		evt_flags == $past(EVENT_PULSE))
		else $error("event lost at clear");

	AST_PORTS: assert property (RD_REQ && hit_g3 |=> // R7
		RD_DATA == {8'h00, $past(GENERAL_PORT_THREE)})
		else $error("port three state wrong");

	AST_CORR_TAIL: assert property (RD_REQ && hit_c3 |=> // R14
		RD_DATA[7:4] == $past(RX_CORRECTED[3:0]) && RD_DATA[3:0] == $past(DECODE_STATUS))
		else $error("corrected tail word wrong");

	AST_RAW_ORDER: assert property (RD_REQ && hit_r0 |=> // R10
		RD_DATA[7:0] == $past(RX_RAW[39:32]))
		else $error("raw byte order wrong");

	AST_TONE: assert property (RD_REQ && hit_tone |=> // R13
		RD_DATA == {4'h0, $past(TONE_OFFSET)})
		else $error("tone measurement wrong");

	AST_ACK_ONCE: assert property (!RD_REQ |=> !RD_ACK)
		else $error("answer without request");

	// invalid tone band passes as the zero code
	AST_BAND_INVALID: assert property (RD_REQ && hit_p1 && TONE_BAND == 2'b00 |=> // R2
		RD_DATA[7:6] == 2'b00)
		else $error("invalid band code wrong");

	// remaining port, received-word, conversion result and tone sign answers
	AST_PORT_ONE: assert property (RD_REQ && hit_g1 |=> // R7
		RD_DATA == {4'h0, $past(GENERAL_PORT_ONE)})
		else $error("port one state wrong");

	AST_PORT_TWO: assert property (RD_REQ && hit_g2 |=> // R7
		RD_DATA == {4'h0, $past(GENERAL_PORT_TWO)})
		else $error("port two state wrong");

	AST_CORR_BYTE0: assert property (RD_REQ && hit_c0 |=> // R8
		RD_DATA == {4'h0, $past(RX_CORRECTED[27:20])})
		else $error("corrected byte zero wrong");

	AST_CORR_BYTE1: assert property (RD_REQ && hit_c1 |=> // R8
		RD_DATA == {4'h0, $past(RX_CORRECTED[19:12])})
		else $error("corrected byte one wrong");

	AST_CORR_BYTE2: assert property (RD_REQ && hit_c2 |=> // R8
		RD_DATA == {4'h0, $past(RX_CORRECTED[11:4])})
		else $error("corrected byte two wrong");

	AST_CORR_TAIL_TOP: assert property (RD_REQ && hit_c3 |=> // R9
		RD_DATA[11:8] == 4'h0)
		else $error("corrected tail upper bits set");

	AST_RAW_BYTE1: assert property (RD_REQ && hit_r1 |=> // R10
		RD_DATA == {4'h0, $past(RX_RAW[31:24])})
		else $error("raw byte one wrong");

	AST_RAW_BYTE2: assert property (RD_REQ && hit_r2 |=> // R10
		RD_DATA == {4'h0, $past(RX_RAW[23:16])})
		else $error("raw byte two wrong");

	AST_RAW_BYTE3: assert property (RD_REQ && hit_r3 |=> // R10
		RD_DATA == {4'h0, $past(RX_RAW[15:8])})
		else $error("raw byte three wrong");

	AST_RAW_BYTE4: assert property (RD_REQ && hit_r4 |=> // R10
		RD_DATA == {4'h0, $past(RX_RAW[7:0])})
		else $error("raw byte four wrong");

	AST_VOTE_REPEATS: assert property (RD_REQ && hit_vr |=> // R11
		RD_DATA == {8'h00, $past(VOTE_REPEATS)})
		else $error("repeat count wrong");

	AST_ADC_RESULT: assert property (RD_REQ && hit_adc |=> // R12
		RD_DATA == {4'h0, $past(AUDIO_ADC_RESULT)})
		else $error("conversion result wrong");

	AST_TONE_SIGN: assert property (RD_REQ && hit_tone && TONE_OFFSET[7] |=> // R15
		RD_DATA[7] && RD_DATA[11:8] == 4'h0)
		else $error("tone sign lost");

	// unmapped addresses and the answer handshake
	AST_UNMAPPED: assert property (RD_REQ && !hit_any |=>
		RD_ACK && RD_DATA == 12'h000)
		else $error("unmapped address not zero");

	AST_ACK_AFTER_REQ: assert property (RD_REQ |=>
		RD_ACK)
		else $error("request without answer");

	AST_DATA_STANDS: assert property (!RD_REQ |=>
		$stable(RD_DATA))
		else $error("answer changed without request");

	// event bookkeeping beyond the single-case checks
	AST_EVT_NO_SPURIOUS: assert property (EVENT_PULSE == 12'h000 && !evt_read |=> // R6
		evt_flags == $past(evt_flags))
		else $error("event flag changed without cause");

	AST_EVT_READ_CLEARS: assert property (evt_read |=> // R6
		(evt_flags & ~$past(EVENT_PULSE)) == 12'h000)
		else $error("reported flag survived read");

	AST_EVT_ACCUMULATE: assert property (EVENT_PULSE != 12'h000 && !evt_read |=> // R5
		evt_flags == $past(evt_flags | EVENT_PULSE))
		else $error("event flags not accumulated");

	// reset state, checked in the cycle after each cycle with reset applied
	AST_RESET_QUIET: assert property (disable iff (1'b0) SYS_RST |=>
		!RD_ACK && RD_DATA == 12'h000 && evt_flags == 12'h000)
		else $error("reset state wrong");

	COV_EVT_RACE: cover property (evt_read && EVENT_PULSE != 12'h000);
	COV_BAND_HIGH: cover property (RD_REQ && hit_p1 && band == cdsr_pkg::CDSR_BAND_HIGH);
	COV_RAW_SWEEP: cover property (RD_REQ && hit_r0 ##1 RD_REQ && hit_r1);
	COV_UNMAPPED: cover property (RD_REQ && nxt_rd_data == 12'h000 && RD_ADDR == 7'h03);
	COV_TONE_NEGATIVE: cover property (RD_REQ && hit_tone && TONE_OFFSET[7]);

endmodule : cdsr_status_readout

`default_nettype wire

//--- sim/cdsr_host_model.sv
// host model: issues one-cycle reads and collects the answers
`timescale 1ns/10ps
`default_nettype none

module cdsr_host_model
(
	input wire logic clk, // device clock
	input wire logic rd_ack, // answer valid
	input wire logic [11:0] rd_data, // answer word
	input wire logic audio_busy, // audio interface active
	output var logic rd_req, // read strobe
	output var logic [6:0] rd_addr // read address
);
	// idle bus at time zero
	initial
	begin
		rd_req = 1'b0;
		rd_addr = 7'h7f;
	end

	// one read: strobe for one edge, take data in the answer cycle
	task automatic rd(input logic [6:0] a, output logic [11:0] d, output logic k);
		int n;
		n = 0;
		while (a == 7'h20 && audio_busy === 1'b1 && n < 50)
		begin
			@(posedge clk);
			#1;
			n++;
		end
		rd_req = 1'b1;
		rd_addr = a;
		@(posedge clk);
		#1;
		d = rd_data;
		k = rd_ack;
		rd_req = 1'b0;
		rd_addr = ~a; // released address does not hold its last value
		@(posedge clk);
		#1;
	endtask : rd
endmodule : cdsr_host_model
`default_nettype wire

//--- sim/tb_cellular_data_status_readout.sv
// self-checking bench of the status readout bank
`timescale 1ns/10ps
`default_nettype none

`define CHK(nm, e, g) num_checks++; if ((g) !== (e)) begin failures++; \
	$display("[FAIL] %s exp %h got %h", nm, e, g); end

module tb_cellular_data_status_readout;
	logic clk, rst, req, ack, k;
	logic [6:0] addr;
	logic [11:0] data, d, ev;
	logic [5:0] p1;
	logic [1:0] band;
	logic [2:0] p2;
	logic [7:0] g1, g2, adc, tone_frequency_measure;
	logic [3:0] g3, ds, vr;
	logic [27:0] rc;
	logic [39:0] rw;
	int failures = 0;
	int num_checks = 0;
	int cyc = 0;

	cdsr_status_readout cdsr_status_readout_i
	(
		.CLK(clk), .SYS_RST(rst), .RD_REQ(req), .RD_ADDR(addr), .RD_DATA(data),
		.RD_ACK(ack), .RX_DATA_AVAIL(p1[0]), .TX_BUF_AVAIL(p1[1]),
		.TX_ABORT_ARB(p1[2]), .TX_ENC_ACTIVE(p1[3]), .RCC_BUSY(p1[4]),
		.TIMER_ZERO(p1[5]), .TONE_BAND(band), .AUDIO_IF_ACTIVE(p2[0]),
		.VOICE_MSG_RX(p2[1]), .CTRL_FRAME_SYNC(p2[2]), .EVENT_PULSE(ev),
		.GENERAL_PORT_ONE(g1), .GENERAL_PORT_TWO(g2), .GENERAL_PORT_THREE(g3),
		.RX_CORRECTED(rc), .DECODE_STATUS(ds), .RX_RAW(rw), .VOTE_REPEATS(vr),
		.AUDIO_ADC_RESULT(adc), .TONE_OFFSET(tone_frequency_measure)
	);

	cdsr_host_model cdsr_host_model_i
	(
		.clk(clk), .rd_ack(ack), .rd_data(data), .audio_busy(p2[0]),
		.rd_req(req), .rd_addr(addr)
	);

	// free-running clock, 10 ns period
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// hang guard
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 2000)
		begin
			failures++;
			conclude();
		end
	end

	// counts and verdict
	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : conclude

	// read one address and compare answer and acknowledge
	task automatic rchk(input logic [6:0] a, input logic [11:0] e, input string nm);
		cdsr_host_model_i.rd(a, d, k);
		`CHK("ack", 1'b1, k)
		`CHK(nm, e, d)
	endtask : rchk

	// one-cycle event strobe, then one quiet edge
	task automatic pulse(input logic [11:0] p);
		ev = p;
		@(posedge clk);
		#1;
		ev = 12'h000;
		@(posedge clk);
		#1;
	endtask : pulse

	// main sequence
	initial
	begin
		rst = 1'b1;
		ev = 12'h000;
		p1 = 6'h2d;
		band = 2'b00;
		p2 = 3'b101;
		{g1, g2, g3} = {8'h3c, 8'hc3, 4'h6};
		{rc, ds, rw} = {28'hbadcafe, 4'hc, 40'h0123456789};
		{vr, adc, tone_frequency_measure} = {4'h9, 8'h5c, 8'h03};
		repeat (2) @(posedge clk);
		#1;
		rst = 1'b0;
		rchk(7'h02, 12'h000, "evt_reset");
		for (int b = 0; b < 4; b++)
		begin
			band = b[1:0];
			rchk(7'h00, {4'h0, band, p1}, "primary");
		end
		rchk(7'h01, {9'h000, p2}, "secondary");
		$display("status words done");
		pulse(12'ha5a);
		rchk(7'h02, 12'ha5a, "evt_set");
		rchk(7'h02, 12'h000, "evt_clear");
		pulse(12'h5a5);
		pulse(12'h5a5);
		ev = 12'h800;
		fork
			cdsr_host_model_i.rd(7'h02, d, k);
			begin
				@(posedge clk);
				#1;
				ev = 12'h000;
			end
		join
		`CHK("evt_same", 12'h5a5, d)
		rchk(7'h02, 12'h800, "evt_kept");
		pulse(12'h0f0);
		rst = 1'b1;
		@(posedge clk);
		#1;
		rst = 1'b0;
		rchk(7'h02, 12'h000, "evt_after_reset");
		$display("events done");
		rchk(7'h04, {4'h0, g1}, "port_one");
		rchk(7'h05, {4'h0, g2}, "port_two");
		rchk(7'h06, {8'h00, g3}, "port_three");
		rchk(7'h10, {4'h0, rc[27:20]}, "corr0");
		rchk(7'h11, {4'h0, rc[19:12]}, "corr1");
		rchk(7'h12, {4'h0, rc[11:4]}, "corr2");
		rchk(7'h13, {4'h0, rc[3:0], ds}, "corr_tail");
		for (int i = 0; i < 5; i++)
			rchk(7'h18 + 7'(i), {4'h0, rw[39 - 8 * i -: 8]}, "raw");
		rchk(7'h1d, {8'h00, vr}, "repeats");
		p2 = 3'b000;
		rchk(7'h20, {4'h0, adc}, "adc");
		rchk(7'h30, 12'h003, "tone");
		tone_frequency_measure = 8'hfb;
		rchk(7'h30, 12'h0fb, "tone_neg");
		rchk(7'h03, 12'h000, "unmapped");
		rchk(7'h7f, 12'h000, "unmapped_top");
		$display("data words done");
		conclude();
	end
endmodule : tb_cellular_data_status_readout
`default_nettype wire
